// ==== logic/hpmon_defs.svh ====
`ifndef HPMON_DEFS_SVH
`define HPMON_DEFS_SVH

`define HPMON_SAMPLE_W 24
// register byte offsets
`define HPMON_REG_PROGRAM 5'h00
`define HPMON_REG_CTRL 5'h04
`define HPMON_REG_STATUS 5'h08
`define HPMON_REG_SOLO 5'h0c
// ctrl fields
`define HPMON_CTRL_SOLO_EN 0
`define HPMON_CTRL_FADER_CTL 1
`define HPMON_CTRL_RST 32'h0000_0001
`define HPMON_PROGRAM_RST 8'h08
// timing
`define HPMON_CLK_HZ 25000000
`define HPMON_MOMENTARY_MS 1000
`define HPMON_HOLD_MS 5000
`define HPMON_MOMENTARY_CYC ((`HPMON_CLK_HZ / 1000) * `HPMON_MOMENTARY_MS)
`define HPMON_HOLD_CYC ((`HPMON_CLK_HZ / 1000) * `HPMON_HOLD_MS)

`endif

// ==== logic/hpmon_pkg.sv ====
package hpmon_pkg;
    typedef logic signed [23:0] hpmon_sample_t;
    // program code: [7:5] class, [4:0] argument
    typedef enum logic [2:0] {
        HPMON_CL_IN_PAIR = 3'h0,
        HPMON_CL_TRK_PAIR = 3'h1,
        HPMON_CL_IN_SOLO = 3'h2,
        HPMON_CL_TRK_SOLO = 3'h3,
        HPMON_CL_IN_MS = 3'h4,
        HPMON_CL_TRK_MS = 3'h5,
        HPMON_CL_IN_SUM = 3'h6,
        HPMON_CL_MISC = 3'h7
    } hpmon_class_t;
    typedef enum logic [2:0] {
        HPMON_S_IDLE = 3'b000,
        HPMON_S_PRESS = 3'b001,
        HPMON_S_LATCH = 3'b011,
        HPMON_S_MOMENT = 3'b010,
        HPMON_S_HOLD = 3'b110,
        HPMON_S_WAIT = 3'b111
    } hpmon_solo_state_t;
endpackage

// ==== logic/hpmon_ms_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module hpmon_ms_decode
    import hpmon_pkg::*;
(
    input wire logic signed [23:0] mid_i,
    input wire logic signed [23:0] side_i,
    output logic signed [23:0] left_o,
    output logic signed [23:0] right_o
);
    // sum at 25 bits, then halve: equal weight, no overflow possible
    wire logic signed [24:0] sum_w = 25'(mid_i) + 25'(side_i);
    wire logic signed [24:0] dif_w = 25'(mid_i) - 25'(side_i);
    assign left_o = sum_w[24:1];
    assign right_o = dif_w[24:1];
endmodule
`default_nettype wire

// ==== logic/hpmon_solo_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "hpmon_defs.svh"
module hpmon_solo_ctl
    import hpmon_pkg::*;
#(
    parameter int MOMENT_CYC = `HPMON_MOMENTARY_CYC,
    parameter int HOLD_CYC = `HPMON_HOLD_CYC
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] sel_sw_i,
    input wire logic solo_function_enable_i,
    input wire logic program_change_i,
    output logic solo_active_o,
    output logic [2:0] solo_input_o,
    output logic hold_o,
    output logic [7:0] settings_open_o
);
    hpmon_solo_state_t st_q, st_d;
    logic [2:0] idx_q;
    logic [27:0] cnt_q;
    logic [7:0] sw_q;
    logic [7:0] settings_q;
    wire logic [7:0] rise_w = sel_sw_i & ~sw_q;
    wire logic any_rise_w = |rise_w;
    wire logic same_held_w = sel_sw_i[idx_q];
    wire logic [2:0] rise_idx_w = enc8(rise_w);

    function automatic logic [2:0] enc8(input logic [7:0] v);
        enc8 = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                enc8 = 3'(i);
            end
        end
    endfunction

    always_comb begin
        st_d = st_q;
        case (st_q)
            HPMON_S_IDLE: if (any_rise_w && solo_function_enable_i) st_d = HPMON_S_PRESS;
            HPMON_S_PRESS: begin
                if (!same_held_w) begin
                    st_d = HPMON_S_LATCH;
                end else if (cnt_q >= 28'(MOMENT_CYC)) begin
                    st_d = HPMON_S_MOMENT;
                end
            end
            HPMON_S_LATCH: begin
                if (program_change_i) begin
                    st_d = HPMON_S_IDLE;
                end else if (any_rise_w) begin
                    st_d = (rise_idx_w == idx_q) ? HPMON_S_WAIT : HPMON_S_PRESS;
                end
            end
            HPMON_S_MOMENT: begin
                if (!same_held_w) begin
                    st_d = HPMON_S_IDLE;
                // count restarts on entry, so the momentary time is already spent
                end else if (cnt_q >= 28'(HOLD_CYC - MOMENT_CYC)) begin
                    st_d = HPMON_S_HOLD;
                end
            end
            HPMON_S_HOLD: begin
                if (program_change_i || any_rise_w) begin
                    st_d = HPMON_S_WAIT;
                end
            end
            HPMON_S_WAIT: if (sel_sw_i == 8'h00) st_d = HPMON_S_IDLE;
            default: st_d = HPMON_S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= HPMON_S_IDLE;
            idx_q <= 3'h0;
            cnt_q <= 28'h0;
            sw_q <= 8'h00;
            settings_q <= 8'h00;
        end else begin
            st_q <= st_d;
            sw_q <= sel_sw_i;
            settings_q <= solo_function_enable_i ? 8'h00 : rise_w;
            if (st_d == HPMON_S_PRESS && st_q != HPMON_S_PRESS) begin
                idx_q <= rise_idx_w;
            end
            cnt_q <= (st_d != st_q) ? 28'h0 : cnt_q + 28'h1;
        end
    end

    assign solo_active_o = (st_q != HPMON_S_IDLE) && (st_q != HPMON_S_WAIT);
    assign solo_input_o = idx_q;
    assign hold_o = (st_q == HPMON_S_HOLD);
    assign settings_open_o = settings_q;
endmodule
`default_nettype wire

// ==== logic/hpmon_matrix.sv ====
// Contract
// - input pair: odd left, even right
// - track pair: first left, second right
// - tracks live when recording, recorded when playing
// - single solo source on both ears
// - ms pair: odd is mid, even side
// - fixed equal mid/side spread
// - track ms decodes played-back tracks; code decodes live tracks when not playing
// - input sums: odd left, even right
// - track groups: two split, one dual mono
// - surround program from three channels
// - use omni and horizontal, drop vertical
// - program exported before volume stage
// - export withdrawn when fader controller selected
// - short press latches solo, repress restores
// - one second hold gives momentary solo
// - five second hold keeps solo
// - solo disabled opens settings only
// - stereo-linked input solos both partners
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hpmon_defs.svh"
module hpmon_matrix
    import hpmon_pkg::*;
#(
    parameter int MOMENT_CYC = `HPMON_MOMENTARY_CYC,
    parameter int HOLD_CYC = `HPMON_HOLD_CYC
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic sample_en_i,
    input wire logic [8*24-1:0] input_i,
    input wire logic [12*24-1:0] track_live_i,
    input wire logic [12*24-1:0] track_play_i,
    input wire logic playing_i,
    input wire logic [3:0] link_i,
    input wire logic [7:0] sel_sw_i,
    input wire logic rotary_change_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic signed [23:0] headphone_path_left_o,
    output logic signed [23:0] headphone_path_right_o,
    output logic signed [23:0] bus_src_left_o,
    output logic signed [23:0] bus_src_right_o,
    output logic bus_src_valid_o,
    output logic hold_o,
    output logic [7:0] settings_open_o
);
    logic [7:0] program_q;
    logic [31:0] ctrl_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic signed [23:0] l_q, r_q;

    function automatic hpmon_sample_t in_at(input logic [8*24-1:0] v, input logic [2:0] i);
        in_at = v[24*i +: 24];
    endfunction

    function automatic hpmon_sample_t trk_at(input logic [12*24-1:0] v, input logic [3:0] i);
        trk_at = (i < 4'd12) ? v[24*i +: 24] : 24'sh0;
    endfunction

    // group sum with a 1/8 share per member keeps headroom for eight members
    function automatic hpmon_sample_t share(input logic signed [27:0] acc);
        share = acc[26:3];
    endfunction

    // registers
    wire logic sel_program_w = avs_address_i == `HPMON_REG_PROGRAM;
    wire logic sel_ctrl_w = avs_address_i == `HPMON_REG_CTRL;
    wire logic sel_status_w = avs_address_i == `HPMON_REG_STATUS;
    wire logic sel_solo_w = avs_address_i == `HPMON_REG_SOLO;
    wire logic req_w = (avs_read_i || avs_write_i) && !ack_q;
    // write lands only on the edge that sees waitrequest low
    wire logic wr_w = avs_write_i && ack_q;
    wire logic solo_en_w = ctrl_q[`HPMON_CTRL_SOLO_EN];
    wire logic fader_ctl_w = ctrl_q[`HPMON_CTRL_FADER_CTL];
    wire logic sw_prog_w = wr_w && sel_program_w && avs_byteenable_i[0];

    logic solo_active_w;
    logic [2:0] solo_idx_w;

    hpmon_solo_ctl #(
        .MOMENT_CYC(MOMENT_CYC),
        .HOLD_CYC(HOLD_CYC)
    ) u_solo (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .sel_sw_i(sel_sw_i),
        .solo_function_enable_i(solo_en_w),
        .program_change_i(rotary_change_i || sw_prog_w),
        .solo_active_o(solo_active_w),
        .solo_input_o(solo_idx_w),
        .hold_o(hold_o),
        .settings_open_o(settings_open_o)
    );

    // source selection
    wire hpmon_class_t cls_w = hpmon_class_t'(program_q[7:5]);
    wire logic [4:0] arg_w = program_q[4:0];
    wire logic [12*24-1:0] trk_w = playing_i ? track_play_i : track_live_i;
    wire logic [2:0] in_odd_w = {arg_w[1:0], 1'b0};
    wire logic [3:0] trk_odd_w = {arg_w[2:0], 1'b0};
    wire hpmon_sample_t in_a_w = in_at(input_i, in_odd_w);
    wire hpmon_sample_t in_b_w = in_at(input_i, in_odd_w | 3'h1);
    wire hpmon_sample_t tr_a_w = trk_at(trk_w, trk_odd_w);
    wire hpmon_sample_t tr_b_w = trk_at(trk_w, trk_odd_w | 4'h1);
    wire hpmon_sample_t in_solo_w = in_at(input_i, arg_w[2:0]);
    wire hpmon_sample_t tr_solo_w = trk_at(trk_w, arg_w[3:0]);
    wire logic ms_trk_w = cls_w == HPMON_CL_TRK_MS;
    wire hpmon_sample_t ms_mid_w = ms_trk_w ? tr_a_w : in_a_w;
    wire hpmon_sample_t ms_side_w = ms_trk_w ? tr_b_w : in_b_w;
    logic signed [23:0] ms_l_w, ms_r_w;

    hpmon_ms_decode u_ms (
        .mid_i(ms_mid_w),
        .side_i(ms_side_w),
        .left_o(ms_l_w),
        .right_o(ms_r_w)
    );

    // solo from selector switch; linked pair brings both partners
    wire logic solo_linked_w = link_i[solo_idx_w[2:1]];
    wire logic [2:0] solo_pair_w = {solo_idx_w[2:1], 1'b0};
    wire hpmon_sample_t sw_one_w = in_at(input_i, solo_idx_w);
    wire hpmon_sample_t sw_l_w = solo_linked_w ? in_at(input_i, solo_pair_w) : sw_one_w;
    wire hpmon_sample_t sw_r_w =
        solo_linked_w ? in_at(input_i, solo_pair_w | 3'h1) : sw_one_w;

    // summed groups: input sum arg 0..3 => inputs 1-4, 1-6, 1-8, 1-8; misc track groups decoded below
    logic signed [27:0] acc_l, acc_r, acc_m;
    logic signed [23:0] prog_l, prog_r;
    logic [3:0] n_in;
    always_comb begin
        acc_l = 28'sh0;
        acc_r = 28'sh0;
        acc_m = 28'sh0;
        n_in = 4'd4 + {arg_w[1:0], 1'b0};
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < n_in) begin
                if (i[0]) begin
                    acc_r = acc_r + 28'(in_at(input_i, 3'(i)));
                end else begin
                    acc_l = acc_l + 28'(in_at(input_i, 3'(i)));
                end
            end
        end
        if (cls_w == HPMON_CL_MISC) begin
            // arg[4]=0: split groups over first arg[3:0]+2 track pairs
            // arg[4]=1: dual mono of the first arg[3:0]+2 tracks
            acc_l = 28'sh0;
            acc_r = 28'sh0;
            for (int t = 0; t < 12; t++) begin
                if (!arg_w[4] && 5'(t / 2) < 5'(arg_w[3:0]) + 5'd2) begin
                    if (t % 2 == 1) begin
                        acc_r = acc_r + 28'(trk_at(trk_w, 4'(t)));
                    end else begin
                        acc_l = acc_l + 28'(trk_at(trk_w, 4'(t)));
                    end
                end
                if (arg_w[4] && (t < 2 || 5'(t) < 5'(arg_w[3:0]) + 5'd2)) begin
                    acc_m = acc_m + 28'(trk_at(trk_w, 4'(t)));
                end
            end
        end
    end

    // surround: omni and front axis make the mid, side axis the side; vertical never read
    wire logic sur_trk_w = arg_w[0];
    wire hpmon_sample_t sur_w_w = sur_trk_w ? trk_at(trk_w, 4'd0) : in_at(input_i, 3'd0);
    wire hpmon_sample_t sur_x_w = sur_trk_w ? trk_at(trk_w, 4'd1) : in_at(input_i, 3'd1);
    wire hpmon_sample_t sur_y_w = sur_trk_w ? trk_at(trk_w, 4'd2) : in_at(input_i, 3'd2);
    logic signed [23:0] sur_f_w, sur_l_w, sur_r_w;

    hpmon_ms_decode u_front (
        .mid_i(sur_w_w),
        .side_i(sur_x_w),
        .left_o(sur_f_w),
        .right_o()
    );

    hpmon_ms_decode u_surround (
        .mid_i(sur_f_w),
        .side_i(sur_y_w),
        .left_o(sur_l_w),
        .right_o(sur_r_w)
    );

    always_comb begin
        prog_l = 24'sh0;
        prog_r = 24'sh0;
        case (cls_w)
            HPMON_CL_IN_PAIR: begin
                prog_l = in_a_w;
                prog_r = in_b_w;
            end
            HPMON_CL_TRK_PAIR: begin
                prog_l = tr_a_w;
                prog_r = tr_b_w;
            end
            HPMON_CL_IN_SOLO: begin
                prog_l = in_solo_w;
                prog_r = in_solo_w;
            end
            HPMON_CL_TRK_SOLO: begin
                prog_l = tr_solo_w;
                prog_r = tr_solo_w;
            end
            HPMON_CL_IN_MS, HPMON_CL_TRK_MS: begin
                prog_l = ms_l_w;
                prog_r = ms_r_w;
            end
            HPMON_CL_IN_SUM: begin
                if (arg_w[4]) begin
                    prog_l = sur_l_w;
                    prog_r = sur_r_w;
                end else begin
                    prog_l = share(acc_l);
                    prog_r = share(acc_r);
                end
            end
            HPMON_CL_MISC: begin
                if (arg_w[4]) begin
                    prog_l = share(acc_m >>> 1);
                    prog_r = share(acc_m >>> 1);
                end else begin
                    prog_l = share(acc_l);
                    prog_r = share(acc_r);
                end
            end
            default: begin
                prog_l = 24'sh0;
                prog_r = 24'sh0;
            end
        endcase
        if (solo_active_w) begin
            prog_l = sw_l_w;
            prog_r = sw_r_w;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            l_q <= 24'sh0;
            r_q <= 24'sh0;
        end else if (sample_en_i) begin
            l_q <= prog_l;
            r_q <= prog_r;
        end
    end

    // bus export taps before volume, which sits downstream of this block
    assign headphone_path_left_o = l_q;
    assign headphone_path_right_o = r_q;
    assign bus_src_left_o = fader_ctl_w ? 24'sh0 : l_q;
    assign bus_src_right_o = fader_ctl_w ? 24'sh0 : r_q;
    assign bus_src_valid_o = !fader_ctl_w;

    // avalon slave: one wait state, answer on the second edge
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            program_q <= `HPMON_PROGRAM_RST;
            ctrl_q <= `HPMON_CTRL_RST;
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= req_w;
            if (sw_prog_w) begin
                program_q <= avs_writedata_i[7:0];
            end
            if (wr_w && sel_ctrl_w && avs_byteenable_i[0]) begin
                ctrl_q <= {30'h0, avs_writedata_i[1:0]};
            end
            if (req_w) begin
                rdata_q <= sel_program_w ? {24'h0, program_q} :
                           sel_ctrl_w ? ctrl_q :
                           sel_status_w ? {28'h0, bus_src_valid_o, playing_i, hold_o,
                                           solo_active_w} :
                           sel_solo_w ? {29'h0, solo_idx_w} : 32'h0;
            end
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    assign avs_readdata_o = rdata_q;
endmodule
`default_nettype wire

// ==== verification/hpmon_matrix_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module hpmon_matrix_assertions #(
    parameter int MOMENT_CYC = 20,
    parameter int HOLD_CYC = 100
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic sample_en_i,
    input wire logic [7:0] sel_sw_i,
    input wire logic rotary_change_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic signed [23:0] headphone_path_left_o,
    input wire logic signed [23:0] headphone_path_right_o,
    input wire logic signed [23:0] bus_src_left_o,
    input wire logic signed [23:0] bus_src_right_o,
    input wire logic bus_src_valid_o,
    input wire logic hold_o,
    input wire logic [7:0] settings_open_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // saturates so a long hold cannot wrap
    int unsigned held_q;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) held_q <= 0;
        else if (sel_sw_i == 8'h00) held_q <= 0;
        else if (held_q < HOLD_CYC + 8) held_q <= held_q + 1;
    end
    a_bus_withdrawn: assert property (!bus_src_valid_o && !$past(bus_src_valid_o)
        && $past(sample_en_i) |-> bus_src_left_o == 24'h0 && bus_src_right_o == 24'h0)
        else $error("bus source not zero while withdrawn");
    a_bus_follows: assert property (bus_src_valid_o && $past(bus_src_valid_o)
        && $past(sample_en_i) |-> bus_src_left_o == headphone_path_left_o
        && bus_src_right_o == headphone_path_right_o)
        else $error("bus source differs from headphone program");
    a_one_wait: assert property ($rose(avs_read_i) || $rose(avs_write_i)
        |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bus answer not after one wait state");
    a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i > 5'h0c |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_hold_late: assert property ($rose(hold_o) |-> $past(held_q) + 2 >= HOLD_CYC)
        else $error("hold raised before the hold time");
    a_hold_rotary: assert property (hold_o && rotary_change_i |-> ##[1:3] !hold_o)
        else $error("hold kept after rotary change");
    a_open_pulse: assert property (settings_open_o != 8'h00 |=> settings_open_o == 8'h00)
        else $error("settings pulse longer than one cycle");
    a_open_cause: assert property (settings_open_o != 8'h00 |-> (settings_open_o
        & ~($past(sel_sw_i) | $past(sel_sw_i, 2))) == 8'h00)
        else $error("settings pulse without its switch");
endmodule
bind hpmon_matrix hpmon_matrix_assertions #(.MOMENT_CYC(MOMENT_CYC), .HOLD_CYC(HOLD_CYC)) u_chk (
    .sys_clk_i, .nrst_i, .sample_en_i, .sel_sw_i, .rotary_change_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .headphone_path_left_o,
    .headphone_path_right_o, .bus_src_left_o, .bus_src_right_o, .bus_src_valid_o, .hold_o,
    .settings_open_o);
`default_nettype wire

// ==== verification/hpmon_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module hpmon_source_model (
    output logic [8*24-1:0] input_o,
    output logic [12*24-1:0] track_live_o,
    output logic [12*24-1:0] track_play_o
);
    // every channel distinct and a multiple of 128, so swaps show and scaling is exact
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            input_o[24*k+:24] = 24'((k + 1) * 32'h80);
        end
        for (int t = 0; t < 12; t++) begin
            track_live_o[24*t+:24] = 24'((t + 1) * 32'h800);
            track_play_o[24*t+:24] = 24'(32'h100000 + (t + 1) * 32'h80);
        end
    end
endmodule
`default_nettype wire

// ==== verification/hpmon_matrix_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module hpmon_matrix_bench;
    import hpmon_pkg::*;
    localparam int MC = 20;
    localparam int HC = 100;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, playing_i = 1'b0, rotary_change_i = 1'b0;
    logic avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [3:0] link_i = 4'h0;
    logic [7:0] sel_sw_i = 8'h00;
    logic [4:0] avs_address_i = 5'h00;
    logic [31:0] avs_writedata_i = 32'h0, rdata;
    wire [8*24-1:0] in_w;
    wire [12*24-1:0] tl_w, tp_w;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, bv, hold_o;
    logic [7:0] so;
    hpmon_sample_t hl, hr, bl, br;
    int mismatches = 0, num_checks = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    hpmon_source_model SRC (.input_o(in_w), .track_live_o(tl_w), .track_play_o(tp_w));
    hpmon_matrix #(.MOMENT_CYC(MC), .HOLD_CYC(HC)) DUT (.sys_clk_i, .nrst_i,
        .sample_en_i(1'b1), .input_i(in_w), .track_live_i(tl_w), .track_play_i(tp_w),
        .playing_i, .link_i, .sel_sw_i, .rotary_change_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
        .avs_waitrequest_o, .headphone_path_left_o(hl), .headphone_path_right_o(hr),
        .bus_src_left_o(bl), .bus_src_right_o(br), .bus_src_valid_o(bv), .hold_o,
        .settings_open_o(so));
    function automatic hpmon_sample_t iv(int k);
        return hpmon_sample_t'((k + 1) * 32'h80);
    endfunction
    function automatic hpmon_sample_t tv(int t);
        return hpmon_sample_t'(playing_i ? 32'h100000 + (t + 1) * 32'h80 : (t + 1) * 32'h800);
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp_s(string n, hpmon_sample_t e, hpmon_sample_t g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_w(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge sys_clk_i);
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_address_i <= a;
        avs_writedata_i <= d;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic lr(string n, hpmon_sample_t l, hpmon_sample_t r);
        repeat (4) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        cmp_s(n, l, hl);
        cmp_s(n, r, hr);
        cmp_s(n, l, bl);
        cmp_s(n, r, br);
    endtask
    task automatic sw_set(logic [7:0] v);
        @(posedge sys_clk_i);
        sel_sw_i <= v;
    endtask
    task automatic sw(int k, int n);
        sw_set(8'h01 << k);
        repeat (n) @(posedge sys_clk_i);
        sw_set(8'h00);
    endtask
    task automatic play(logic p);
        @(posedge sys_clk_i);
        playing_i <= p;
    endtask
    task automatic t_regs;
        bus(1'b0, 5'h00, 32'h0, rdata);
        cmp_w("program reset", 32'h08, rdata);
        bus(1'b0, 5'h04, 32'h0, rdata);
        cmp_w("ctrl reset", 32'h1, rdata);
        wr(5'h10, 32'hff);
        bus(1'b0, 5'h10, 32'h0, rdata);
        cmp_w("unmapped", 32'h0, rdata);
        lr("default pair", iv(0), iv(1));
        $display("test regs done");
    endtask
    task automatic t_routes;
        for (int p = 0; p < 4; p++) begin
            wr(5'h00, 32'(p));
            lr("input pair", iv(2 * p), iv(2 * p + 1));
            wr(5'h00, 32'h80 | p);
            lr("input ms", (iv(2 * p) + iv(2 * p + 1)) / 2, (iv(2 * p) - iv(2 * p + 1)) / 2);
        end
        for (int k = 0; k < 8; k++) begin
            wr(5'h00, 32'h40 | k);
            lr("input solo", iv(k), iv(k));
        end
        for (int pl = 0; pl < 2; pl++) begin
            play(pl[0]);
            for (int a = 0; a < 6; a++) begin
                wr(5'h00, 32'h20 | a);
                lr("track pair", tv(2 * a), tv(2 * a + 1));
                wr(5'h00, 32'ha0 | a);
                lr("track ms", (tv(2 * a) + tv(2 * a + 1)) / 2, (tv(2 * a) - tv(2 * a + 1)) / 2);
            end
            for (int t = 0; t < 12; t++) begin
                wr(5'h00, 32'h60 | t);
                lr("track solo", tv(t), tv(t));
            end
        end
        $display("test routes done");
    endtask
    task automatic t_sums;
        int l, r;
        for (int n = 0; n < 3; n++) begin
            wr(5'h00, 32'hc0 | n);
            l = 0;
            r = 0;
            for (int i = 0; i < 4 + 2 * n; i += 2) begin
                l += iv(i);
                r += iv(i + 1);
            end
            lr("input sum", hpmon_sample_t'(l / 8), hpmon_sample_t'(r / 8));
        end
        wr(5'h00, 32'hd0);
        l = (iv(0) + iv(1)) / 2;
        r = iv(2);
        lr("input surround", (l + r) / 2, (l - r) / 2);
        wr(5'h00, 32'hd1);
        l = (tv(0) + tv(1)) / 2;
        r = tv(2);
        lr("track surround", (l + r) / 2, (l - r) / 2);
        wr(5'h00, 32'he0);
        lr("track split sum", (tv(0) + tv(2)) / 8, (tv(1) + tv(3)) / 8);
        wr(5'h00, 32'hf0);
        lr("track dual mono", (tv(0) + tv(1)) / 16, (tv(0) + tv(1)) / 16);
        $display("test sums done");
    endtask
    task automatic t_export;
        wr(5'h00, 32'h00);
        wr(5'h04, 32'h3);
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        cmp_w("bus valid", 32'h0, {31'h0, bv});
        cmp_s("bus left", 24'h0, bl);
        cmp_s("hp left", iv(0), hl);
        wr(5'h04, 32'h1);
        lr("bus back", iv(0), iv(1));
        $display("test export done");
    endtask
    task automatic t_solo;
        logic seen;
        @(posedge sys_clk_i);
        link_i <= 4'h0;
        sw(2, 3);
        lr("latched solo", iv(2), iv(2));
        sw(2, 3);
        lr("latch restore", iv(0), iv(1));
        sw_set(8'h10);
        repeat (MC + 2) @(posedge sys_clk_i);
        lr("momentary solo", iv(4), iv(4));
        sw_set(8'h00);
        lr("momentary end", iv(0), iv(1));
        sw_set(8'h20);
        repeat (HC + 5) @(posedge sys_clk_i);
        sw_set(8'h00);
        lr("hold solo", iv(5), iv(5));
        cmp_w("hold flag", 32'h1, {31'h0, hold_o});
        bus(1'b0, 5'h08, 32'h0, rdata);
        cmp_w("status hold", 32'hb, rdata);
        bus(1'b0, 5'h0c, 32'h0, rdata);
        cmp_w("solo index", 32'h5, rdata);
        @(posedge sys_clk_i);
        rotary_change_i <= 1'b1;
        @(posedge sys_clk_i);
        rotary_change_i <= 1'b0;
        lr("hold end", iv(0), iv(1));
        cmp_w("hold clear", 32'h0, {31'h0, hold_o});
        @(posedge sys_clk_i);
        link_i <= 4'h2;
        sw(2, 3);
        lr("linked solo", iv(2), iv(3));
        sw(2, 3);
        lr("linked restore", iv(0), iv(1));
        wr(5'h04, 32'h0);
        sw_set(8'h02);
        seen = 1'b0;
        repeat (6) begin
            @(negedge sys_clk_i);
            seen = seen | (so[1] === 1'b1);
        end
        sw_set(8'h00);
        cmp_w("settings open", 32'h1, {31'h0, seen});
        lr("no solo", iv(0), iv(1));
        wr(5'h04, 32'h1);
        $display("test solo done");
    endtask
    initial begin
        repeat (20) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        t_regs();
        t_routes();
        t_sums();
        play(1'b0);
        t_export();
        t_solo();
        close_out();
    end
endmodule
`default_nettype wire
